// ==== common/gpio_pkg.sv ====
package gpio_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int PA_W   = 5;
  localparam int PB_W   = 8;
  localparam int AN_W   = 4;
  localparam int WATCH_W = 4;

  localparam logic [7:0] FIRST_PORT_PIN_DATA_ADDR  = 8'h05;
  localparam logic [7:0] SECOND_PORT_PIN_DATA_ADDR = 8'h06;
  localparam logic [7:0] IRQ_CONTROL_ADDR          = 8'h0b;
  localparam logic [7:0] FIRST_PORT_BIT_OP_ADDR    = 8'h25;
  localparam logic [7:0] SECOND_PORT_BIT_OP_ADDR   = 8'h26;
  localparam logic [7:0] OPTION_ADDR               = 8'h81;
  localparam logic [7:0] FIRST_PORT_DIRECTION_ADDR = 8'h85;
  localparam logic [7:0] SECOND_PORT_DIR_ADDR      = 8'h86;
  localparam logic [7:0] ANALOG_PIN_CONFIG_ADDR    = 8'h9f;

  localparam logic [4:0] FIRST_DIR_RESET   = 5'h1f;
  localparam logic [7:0] SECOND_DIR_RESET  = 8'hff;
  localparam logic [7:0] OPTION_RESET      = 8'hff;
  localparam logic [1:0] PIN_CONFIG_RESET  = 2'h0;
  localparam logic [4:0] FIRST_LATCH_RESET = 5'h00;
  localparam logic [7:0] SECOND_LATCH_RESET = 8'h00;

  localparam int PULLUP_DISABLE_N_BIT = 7;
  localparam int PORT_CHANGE_FLAG_BIT = 0;
  localparam int PORT_CHANGE_EN_BIT   = 3;
  localparam int TIMER_CLOCK_BIT      = 4;
  localparam int EXT_IRQ_BIT          = 0;
  localparam int PROG_CLK_BIT         = 6;
  localparam int PROG_DATA_BIT        = 7;
  localparam int WATCH_LSB            = 4;
  localparam int BIT_OP_VALUE_BIT     = 7;

  localparam logic [1:0] CFG_ALL_ANALOG  = 2'h0;
  localparam logic [1:0] CFG_REF_ON_PIN3 = 2'h1;
  localparam logic [1:0] CFG_TWO_ANALOG  = 2'h2;
  localparam logic [1:0] CFG_ALL_DIGITAL = 2'h3;

  localparam logic [3:0] AN_MASK_ALL  = 4'hf;
  localparam logic [3:0] AN_MASK_TWO  = 4'h3;
  localparam logic [3:0] AN_MASK_NONE = 4'h0;

endpackage

// ==== hw/dual_port_gpio.sv ====
// How it works
// - First port keeps a 5-bit output latch
// - First port direction set means pin floats
// - First port read gives pins, write latch
// - Bit-op writes store modified sampled pin levels
// - Bit 4 feeds timer clock, open-drain
// - Two config bits pick analog or digital
// - Reset leaves analog pins, reading zero
// - Direction still drives pins in analog use
// - Second port is 8-bit bidirectional
// - Cleared option bit 7 enables pull-ups
// - Output pins never get a pull-up
// - Pull-ups off after power-on reset
// - Only upper four input pins watched
// - Mismatch with last read sets flag
// - Port-change event can wake from sleep
// - Persisting mismatch keeps setting flag
// - Second-port data reads, data writes and bit-op writes refresh capture
// - Bit 0 doubles as external interrupt
// - Bits 6, 7 serve serial programming
// - Enabled programming mode blocks GPIO driving of bits 6, 7; bit 0 stays drivable
//
// Our own choice: strobed register access.
module dual_port_gpio #(
  parameter int FIRST_W  = gpio_pkg::PA_W,
  parameter int SECOND_W = gpio_pkg::PB_W
) (
  input  wire logic                        clk_in,
  input  wire logic                        srst_in,
  input  wire logic [gpio_pkg::ADDR_W-1:0] addr_in,
  input  wire logic [gpio_pkg::DATA_W-1:0] wdata_in,
  input  wire logic                        wr_in,
  input  wire logic                        rd_in,
  output logic      [gpio_pkg::DATA_W-1:0] rdata_out,
  input  wire logic [FIRST_W-1:0]          first_port_pins_in,
  output logic      [FIRST_W-1:0]          first_port_pins_out,
  output logic      [FIRST_W-1:0]          first_port_pins_oe_out,
  output logic      [gpio_pkg::AN_W-1:0]   analog_sel_out,
  output logic                             vref_sel_out,
  output logic                             timer_clock_pin_out,
  input  wire logic [SECOND_W-1:0]         second_port_pins_in,
  output logic      [SECOND_W-1:0]         second_port_pins_out,
  output logic      [SECOND_W-1:0]         second_port_pins_oe_out,
  output logic      [SECOND_W-1:0]         pullup_en_out,
  output logic      [SECOND_W-1:0]         schmitt_sel_out,
  input  wire logic                        ext_irq_en_in,
  input  wire logic                        prog_mode_in,
  output logic                             ext_irq_pin_out,
  output logic                             prog_clk_out,
  output logic                             prog_data_out,
  output logic                             port_change_flag_out,
  output logic                             wake_out
);

  logic [FIRST_W-1:0]          first_latch_q;
  logic [FIRST_W-1:0]          first_port_direction_q;
  logic [1:0]                  pin_config_q;
  logic [SECOND_W-1:0]         second_latch_q;
  logic [SECOND_W-1:0]         second_port_direction_q;
  logic [gpio_pkg::DATA_W-1:0] option_q;
  logic                        port_change_flag_q;
  logic                        port_change_en_q;
  logic [gpio_pkg::WATCH_W-1:0] capture_q;
  logic [gpio_pkg::DATA_W-1:0] rdata_q;

  logic [gpio_pkg::AN_W-1:0]   analog_mask;
  logic [FIRST_W-1:0]          first_read;
  logic [gpio_pkg::WATCH_W-1:0] watch_pins;
  logic [gpio_pkg::WATCH_W-1:0] watch_inputs;
  logic                        mismatch;
  logic                        second_access;
  logic [FIRST_W-1:0]          first_bit_op;
  logic [SECOND_W-1:0]         second_bit_op;
  logic [gpio_pkg::DATA_W-1:0] rdata_d;
  logic [2:0]                  op_index;
  logic                        op_value;

  // Register write decode
  logic wr_first_data;
  logic wr_first_dir;
  logic wr_first_op;
  logic wr_config;
  logic wr_second_data;
  logic wr_second_dir;
  logic wr_second_op;
  logic wr_option;
  logic wr_irq;
  logic rd_second_data;

  assign wr_first_data  = wr_in &&
                          addr_in == gpio_pkg::FIRST_PORT_PIN_DATA_ADDR;
  assign wr_first_dir   = wr_in &&
                          addr_in == gpio_pkg::FIRST_PORT_DIRECTION_ADDR;
  assign wr_first_op    = wr_in &&
                          addr_in == gpio_pkg::FIRST_PORT_BIT_OP_ADDR;
  assign wr_config      = wr_in &&
                          addr_in == gpio_pkg::ANALOG_PIN_CONFIG_ADDR;
  assign wr_second_data = wr_in &&
                          addr_in == gpio_pkg::SECOND_PORT_PIN_DATA_ADDR;
  assign wr_second_dir  = wr_in &&
                          addr_in == gpio_pkg::SECOND_PORT_DIR_ADDR;
  assign wr_second_op   = wr_in &&
                          addr_in == gpio_pkg::SECOND_PORT_BIT_OP_ADDR;
  assign wr_option      = wr_in && addr_in == gpio_pkg::OPTION_ADDR;
  assign wr_irq         = wr_in && addr_in == gpio_pkg::IRQ_CONTROL_ADDR;
  assign rd_second_data = rd_in &&
                          addr_in == gpio_pkg::SECOND_PORT_PIN_DATA_ADDR;

  assign op_index = wdata_in[2:0];
  assign op_value = wdata_in[gpio_pkg::BIT_OP_VALUE_BIT];

  // Analog pin selection from the configuration field
  always_comb begin
    unique case (pin_config_q)
      gpio_pkg::CFG_ALL_ANALOG:  analog_mask = gpio_pkg::AN_MASK_ALL;
      gpio_pkg::CFG_REF_ON_PIN3: analog_mask = gpio_pkg::AN_MASK_ALL;
      gpio_pkg::CFG_TWO_ANALOG:  analog_mask = gpio_pkg::AN_MASK_TWO;
      gpio_pkg::CFG_ALL_DIGITAL: analog_mask = gpio_pkg::AN_MASK_NONE;
    endcase
  end

  assign analog_sel_out = analog_mask;
  assign vref_sel_out   = pin_config_q == gpio_pkg::CFG_REF_ON_PIN3;

  // Analog pins read as zero; bit 4 has no analog role
  always_comb begin
    first_read = first_port_pins_in;
    first_read[gpio_pkg::AN_W-1:0] =
      first_port_pins_in[gpio_pkg::AN_W-1:0] & ~analog_mask;
  end

  // Bit operations sample the pins, not the latch
  always_comb begin
    first_bit_op = first_read;
    if (op_index < 3'(FIRST_W)) begin
      first_bit_op[op_index] = op_value;
    end
    second_bit_op = second_port_pins_in;
    second_bit_op[op_index] = op_value;
  end

  // First port output latch
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      first_latch_q <= gpio_pkg::FIRST_LATCH_RESET;
    end else if (wr_first_data) begin
      first_latch_q <= wdata_in[FIRST_W-1:0];
    end else if (wr_first_op) begin
      first_latch_q <= first_bit_op;
    end
  end

  // First port direction
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      first_port_direction_q <= gpio_pkg::FIRST_DIR_RESET;
    end else if (wr_first_dir) begin
      first_port_direction_q <= wdata_in[FIRST_W-1:0];
    end
  end

  // Pin configuration field
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      pin_config_q <= gpio_pkg::PIN_CONFIG_RESET;
    end else if (wr_config) begin
      pin_config_q <= wdata_in[1:0];
    end
  end

  // Direction drives even analog pins, so software keeps them set
  genvar ga;
  generate
    for (ga = 0; ga < FIRST_W; ga++) begin : g_first
      if (ga == gpio_pkg::TIMER_CLOCK_BIT) begin : g_od
        // Open drain: only ever pulls low
        assign first_port_pins_out[ga]    = 1'b0;
        assign first_port_pins_oe_out[ga] =
          ~first_port_direction_q[ga] & ~first_latch_q[ga];
      end else begin : g_cmos
        assign first_port_pins_out[ga]    = first_latch_q[ga];
        assign first_port_pins_oe_out[ga] =
          ~first_port_direction_q[ga];
      end
    end
  endgenerate

  assign timer_clock_pin_out =
    first_port_pins_in[gpio_pkg::TIMER_CLOCK_BIT];

  // Second port output latch
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      second_latch_q <= gpio_pkg::SECOND_LATCH_RESET;
    end else if (wr_second_data) begin
      second_latch_q <= wdata_in[SECOND_W-1:0];
    end else if (wr_second_op) begin
      second_latch_q <= second_bit_op;
    end
  end

  // Second port direction
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      second_port_direction_q <= gpio_pkg::SECOND_DIR_RESET;
    end else if (wr_second_dir) begin
      second_port_direction_q <= wdata_in[SECOND_W-1:0];
    end
  end

  // Option register; only the pull-up bit acts here
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      option_q <= gpio_pkg::OPTION_RESET;
    end else if (wr_option) begin
      option_q <= wdata_in;
    end
  end

  // Serial programming takes bits 6 and 7 away from GPIO
  genvar gb;
  generate
    for (gb = 0; gb < SECOND_W; gb++) begin : g_second
      logic alt_busy;
      if (gb == gpio_pkg::PROG_CLK_BIT ||
          gb == gpio_pkg::PROG_DATA_BIT) begin : g_prog
        assign alt_busy = prog_mode_in;
        assign schmitt_sel_out[gb] = prog_mode_in;
      end else if (gb == gpio_pkg::EXT_IRQ_BIT) begin : g_irq
        // Pin stays drivable so firmware can self-trigger
        assign alt_busy = 1'b0;
        assign schmitt_sel_out[gb] = ext_irq_en_in;
      end else begin : g_plain
        assign alt_busy = 1'b0;
        assign schmitt_sel_out[gb] = 1'b0;
      end
      assign second_port_pins_out[gb]    = second_latch_q[gb];
      assign second_port_pins_oe_out[gb] =
        ~second_port_direction_q[gb] & ~alt_busy;
      assign pullup_en_out[gb] =
        ~option_q[gpio_pkg::PULLUP_DISABLE_N_BIT] &
        second_port_direction_q[gb];
    end
  endgenerate

  assign ext_irq_pin_out =
    second_port_pins_in[gpio_pkg::EXT_IRQ_BIT];
  assign prog_clk_out  =
    prog_mode_in & second_port_pins_in[gpio_pkg::PROG_CLK_BIT];
  assign prog_data_out =
    prog_mode_in & second_port_pins_in[gpio_pkg::PROG_DATA_BIT];

  // Change detection on the upper four pins
  assign watch_pins =
    second_port_pins_in[gpio_pkg::WATCH_LSB +: gpio_pkg::WATCH_W];
  assign watch_inputs =
    second_port_direction_q[gpio_pkg::WATCH_LSB +: gpio_pkg::WATCH_W];
  assign mismatch =
    |((watch_pins ^ capture_q) & watch_inputs);

  assign second_access = rd_second_data || wr_second_data ||
                         wr_second_op;

  // Polling re-captures, ending a live mismatch so a later clear can take
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      capture_q <= '0;
    end else if (second_access) begin
      capture_q <= watch_pins;
    end
  end

  // Set beats clear, so a live mismatch re-asserts the flag
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      port_change_flag_q <= 1'b0;
    end else if (mismatch) begin
      port_change_flag_q <= 1'b1;
    end else if (wr_irq) begin
      port_change_flag_q <= wdata_in[gpio_pkg::PORT_CHANGE_FLAG_BIT];
    end
  end

  // Change enable gates wake-up
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      port_change_en_q <= 1'b0;
    end else if (wr_irq) begin
      port_change_en_q <= wdata_in[gpio_pkg::PORT_CHANGE_EN_BIT];
    end
  end

  assign port_change_flag_out = port_change_flag_q;
  assign wake_out = port_change_flag_q & port_change_en_q;

  // Read multiplexer
  always_comb begin
    rdata_d = '0;
    unique case (addr_in)
      gpio_pkg::FIRST_PORT_PIN_DATA_ADDR: begin
        rdata_d[FIRST_W-1:0] = first_read;
      end
      gpio_pkg::FIRST_PORT_DIRECTION_ADDR: begin
        rdata_d[FIRST_W-1:0] = first_port_direction_q;
      end
      gpio_pkg::ANALOG_PIN_CONFIG_ADDR: begin
        rdata_d[1:0] = pin_config_q;
      end
      gpio_pkg::SECOND_PORT_PIN_DATA_ADDR: begin
        rdata_d[SECOND_W-1:0] = second_port_pins_in;
      end
      gpio_pkg::SECOND_PORT_DIR_ADDR: begin
        rdata_d[SECOND_W-1:0] = second_port_direction_q;
      end
      gpio_pkg::OPTION_ADDR: begin
        rdata_d = option_q;
      end
      gpio_pkg::IRQ_CONTROL_ADDR: begin
        rdata_d[gpio_pkg::PORT_CHANGE_FLAG_BIT] = port_change_flag_q;
        rdata_d[gpio_pkg::PORT_CHANGE_EN_BIT]   = port_change_en_q;
      end
      default: begin
        rdata_d = '0;
      end
    endcase
  end

  // Read data valid only in the cycle after the strobe
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      rdata_q <= '0;
    end else if (rd_in) begin
      rdata_q <= rdata_d;
    end else begin
      rdata_q <= '0;
    end
  end

  assign rdata_out = rdata_q;

endmodule

// ==== tb/dual_port_gpio_test.sv ====
module dual_port_gpio_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_in = 1'b0;
  logic        srst_in = 1'b1;
  logic [7:0]  addr_in = 8'h00;
  logic [7:0]  wdata_in = 8'h00;
  logic        wr_in = 1'b0;
  logic        rd_in = 1'b0;
  logic        eirq_en = 1'b0;
  logic        prog = 1'b0;
  logic [4:0]  a_ext = 5'h00;
  logic [7:0]  b_ext = 8'h00;
  logic [7:0]  b_en = 8'hff;
  logic [7:0]  rdata, b_pins, b_out, b_oe, pu, r, v, d, lat;
  logic [4:0]  a_pins, a_out, a_oe;
  logic        eirq, pclk, pdat, flag, wake;
  logic [31:0] seed = 32'h704a;
  int          n_fail = 0;
  int          compares = 0;
  int          cyc = 0;

  dual_port_gpio dut (
    .clk_in(clk_in), .srst_in(srst_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata),
    .first_port_pins_in(a_pins), .first_port_pins_out(a_out),
    .first_port_pins_oe_out(a_oe), .analog_sel_out(), .vref_sel_out(),
    .timer_clock_pin_out(), .second_port_pins_in(b_pins),
    .second_port_pins_out(b_out), .second_port_pins_oe_out(b_oe),
    .pullup_en_out(pu), .schmitt_sel_out(), .ext_irq_en_in(eirq_en),
    .prog_mode_in(prog), .ext_irq_pin_out(eirq), .prog_clk_out(pclk),
    .prog_data_out(pdat), .port_change_flag_out(flag), .wake_out(wake));
  pin_board board (
    .clk_in(clk_in), .first_drive_in(a_out), .first_oe_in(a_oe),
    .first_ext_in(a_ext), .second_drive_in(b_out), .second_oe_in(b_oe),
    .pullup_in(pu), .second_ext_in(b_ext), .ext_en_in(b_en),
    .first_pins_out(a_pins), .second_pins_out(b_pins));

  initial forever #2 clk_in = ~clk_in;

  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic wrap_up();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] w);
    @(posedge clk_in);
    wr_in <= 1'b1;
    addr_in <= a;
    wdata_in <= w;
    @(posedge clk_in);
    wr_in <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    @(posedge clk_in);
    rd_in <= 1'b1;
    addr_in <= a;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 q = rdata;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    rd(a, r);
    chk(r, e);
  endtask

  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_fail++;
      wrap_up();
    end
  end

  initial begin
    repeat (6) @(posedge clk_in);
    srst_in <= 1'b0;
    a_ext <= 5'h1f;
    #1;
    chk({3'h0, a_oe}, 8'h00);
    rdchk(8'h85, 8'h1f);
    rdchk(8'h9f, 8'h00);
    rdchk(8'h05, 8'h10);
    chk(pu, 8'h00);
    rdchk(8'h40, 8'h00);
    // Analog mode still on here, so bits 3:0 drivers follow direction alone
    for (int i = 0; i < 3; i++) begin
      seed = nxt(seed);
      d = seed[7:0];
      v = seed[15:8];
      wr(8'h85, d);
      wr(8'h05, v);
      chk({3'h0, a_oe}, {3'h0, ~d[4] & ~v[4], ~d[3:0]});
      chk({3'h0, a_out}, {4'h0, v[3:0]});
      rdchk(8'h85, {3'h0, d[4:0]});
    end
    wr(8'h85, 8'h1f);
    for (int c = 0; c < 4; c++) begin
      seed = nxt(seed);
      a_ext <= seed[4:0];
      wr(8'h9f, 8'(c));
      v = {3'h0, seed[4:0]} & ~((c < 2) ? 8'h0f : (c == 2) ? 8'h03 : 8'h00);
      rdchk(8'h05, v);
      rdchk(8'h9f, 8'(c));
    end
    // Upper half inputs, lower half driven from the latch
    wr(8'h86, 8'hf0);
    wr(8'h06, 8'h05);
    lat = 8'h05;
    chk(b_oe, 8'h0f);
    for (int b = 0; b < 8; b++) begin
      seed = nxt(seed);
      b_ext <= seed[7:0];
      wr(8'h26, {seed[8], 4'h0, 3'(b)});
      lat = {seed[7:4], lat[3:0]};
      lat[b] = seed[8];
      chk(b_out, lat);
    end
    rdchk(8'h06, {b_ext[7:4], lat[3:0]});
    wr(8'h81, 8'h7f);
    chk(pu, 8'hf0);
    b_en <= 8'h7f;
    rdchk(8'h06, {1'b1, b_ext[6:4], lat[3:0]});
    b_en <= 8'hff;
    wr(8'h81, 8'hff);
    chk(pu, 8'h00);
    // Capture while inputs, then turn bits 7:5 into outputs
    b_ext <= {~lat[7:5], b_ext[4:0]};
    wr(8'h86, 8'hff);
    rd(8'h06, r);
    repeat (3) @(posedge clk_in); // No polling while watching
    #1;
    wr(8'h0b, 8'h08);
    chk({7'h0, flag}, 8'h00);
    wr(8'h86, 8'h1f);
    repeat (3) @(posedge clk_in);
    #1;
    chk({7'h0, flag}, 8'h00);
    b_ext <= b_ext ^ 8'h10;
    @(posedge clk_in);
    #1;
    chk({6'h0, wake, flag}, 8'h03);
    rdchk(8'h0b, 8'h09);
    wr(8'h0b, 8'h08);
    chk({7'h0, flag}, 8'h01);
    rd(8'h06, r);
    wr(8'h0b, 8'h08);
    chk({6'h0, wake, flag}, 8'h00);
    prog <= 1'b1;
    eirq_en <= 1'b1;
    wr(8'h86, 8'h00);
    chk(b_oe, 8'h3f);
    chk({6'h0, pclk, pdat}, {6'h0, b_ext[6], b_ext[7]});
    chk({7'h0, eirq}, {7'h0, lat[0]});
    wrap_up();
  end
endmodule

// ==== tb/gpio_properties.sv ====
module gpio_checker (
  input wire logic       clk_in,
  input wire logic       srst_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic       wr_in,
  input wire logic       rd_in,
  input wire logic [7:0] rdata_out,
  input wire logic [4:0] first_port_pins_in,
  input wire logic [4:0] first_port_pins_out,
  input wire logic [4:0] first_port_pins_oe_out,
  input wire logic [3:0] analog_sel_out,
  input wire logic       vref_sel_out,
  input wire logic       timer_clock_pin_out,
  input wire logic [7:0] second_port_pins_in,
  input wire logic [7:0] second_port_pins_oe_out,
  input wire logic [7:0] pullup_en_out,
  input wire logic [7:0] schmitt_sel_out,
  input wire logic       ext_irq_en_in,
  input wire logic       prog_mode_in,
  input wire logic       port_change_flag_out,
  input wire logic       wake_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_in); endclocking
  default disable iff (srst_in);
  a_read_idle: assert property (
    !$past(rd_in) |-> rdata_out == 8'h00) else $error("read data not idle");
  a_dir_drive: assert property (
    wr_in && addr_in == 8'h85 |=>
      first_port_pins_oe_out[3:0] == ~$past(wdata_in[3:0]))
    else $error("first port enable wrong");
  a_open_drain: assert property (
    first_port_pins_out[4] == 1'b0 &&
    timer_clock_pin_out == first_port_pins_in[4])
    else $error("timer pin path wrong");
  a_pullup_out: assert property (
    (pullup_en_out & second_port_pins_oe_out) == 8'h00)
    else $error("pull-up on output");
  a_pullup_on: assert property (
    wr_in && addr_in == 8'h81 && !wdata_in[7] ##1 !prog_mode_in |->
      pullup_en_out == ~second_port_pins_oe_out)
    else $error("pull-ups not enabled");
  a_flag_hold: assert property (
    $fell(port_change_flag_out) |-> $past(wr_in) && $past(addr_in) == 8'h0b)
    else $error("flag fell without clear");
  a_flag_quiet: assert property (
    rd_in && addr_in == 8'h06 ##1
      (!wr_in && $stable(second_port_pins_in))[*3] |->
      $stable(port_change_flag_out))
    else $error("flag moved without change");
  a_analog_sel: assert property (
    wr_in && addr_in == 8'h9f |=>
      analog_sel_out == ($past(wdata_in[1]) ?
        {2'h0, {2{~$past(wdata_in[0])}}} : 4'hf) &&
      vref_sel_out == ($past(wdata_in[1:0]) == 2'h1))
    else $error("analog pin select wrong");
  a_wake_flag: assert property (
    wake_out |-> port_change_flag_out) else $error("wake without flag");
  a_schmitt_sel: assert property (
    schmitt_sel_out == {{2{prog_mode_in}}, 5'h00, ext_irq_en_in})
    else $error("input buffer select wrong");
  a_reset_dir: assert property (
    $past(srst_in) |-> first_port_pins_oe_out == 5'h00 &&
      second_port_pins_oe_out == 8'h00) else $error("driver on after reset");
endmodule

bind dual_port_gpio gpio_checker chk (
  .clk_in(clk_in),
  .srst_in(srst_in),
  .addr_in(addr_in),
  .wdata_in(wdata_in),
  .wr_in(wr_in),
  .rd_in(rd_in),
  .rdata_out(rdata_out),
  .first_port_pins_in(first_port_pins_in),
  .first_port_pins_out(first_port_pins_out),
  .first_port_pins_oe_out(first_port_pins_oe_out),
  .analog_sel_out(analog_sel_out),
  .vref_sel_out(vref_sel_out),
  .timer_clock_pin_out(timer_clock_pin_out),
  .second_port_pins_in(second_port_pins_in),
  .second_port_pins_oe_out(second_port_pins_oe_out),
  .pullup_en_out(pullup_en_out),
  .schmitt_sel_out(schmitt_sel_out),
  .ext_irq_en_in(ext_irq_en_in),
  .prog_mode_in(prog_mode_in),
  .port_change_flag_out(port_change_flag_out),
  .wake_out(wake_out)
);

// ==== tb/pin_board.sv ====
module pin_board (
  input  wire logic       clk_in,
  input  wire logic [4:0] first_drive_in,
  input  wire logic [4:0] first_oe_in,
  input  wire logic [4:0] first_ext_in,
  input  wire logic [7:0] second_drive_in,
  input  wire logic [7:0] second_oe_in,
  input  wire logic [7:0] pullup_in,
  input  wire logic [7:0] second_ext_in,
  input  wire logic [7:0] ext_en_in,
  output logic      [4:0] first_pins_out,
  output logic      [7:0] second_pins_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] last_q;
  // Bit 4 drive is always low, so enable alone pulls it down
  assign first_pins_out = (first_oe_in & first_drive_in)
    | (~first_oe_in & first_ext_in);
  // Released pin with no pull-up wanders, never holds
  assign second_pins_out = (second_oe_in & second_drive_in)
    | (~second_oe_in & ext_en_in & second_ext_in)
    | (~second_oe_in & ~ext_en_in & (pullup_in | ~last_q));
  always_ff @(posedge clk_in) begin
    last_q <= second_pins_out;
  end
endmodule
